/* File: buck_seq_map.svh */
// Purpose: named constants of the start-up sequencer
// Assumes: 10 MHz mclk
// Notes:   times in their printed units, counts derived in the code
`ifndef BUCK_SEQ_MAP_SVH
`define BUCK_SEQ_MAP_SVH

`define SEQ_CLK_MHZ        10
`define SEQ_CLK_PERIOD_NS  100
`define SEQ_DELAY_US       6800
`define SEQ_SAMPLE_MAX_US  3400
`define SEQ_SS_TIME_US     6800
`define SEQ_SS_STEPS       64
`define SEQ_SS_BITS        6
`define SEQ_TRIP_BITS      6
`define SEQ_MIN_LOW_NS     425
`define SEQ_NARROW_BEFORE  1
`define SEQ_DUMMY_LAST     1
`define SEQ_EA_INIT_STEPS  1
`define SEQ_TIMER_BITS     17
`define SEQ_WIDTH_BITS     4
`define SEQ_NARROW_BITS    2
`define SEQ_SYNC_WIDTH     9

`endif

/* File: buck_seq_pkg.sv */
// Purpose: types of the start-up sequencer
// Assumes: nothing
// Notes:   gray codes along the power-up path
package buck_seq_pkg;

  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_WAIT_EN = 3'b001,
    ST_DELAY   = 3'b011,
    ST_SAMPLE  = 3'b010,
    ST_RAMP    = 3'b110,
    ST_RUN     = 3'b111,
    ST_HICCUP  = 3'b100
  } seq_state_e;

endpackage

/* File: pin_sync.sv */
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to mclk
// Notes:   output follows stage three once stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] agree;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign agree = ~(s2_q ^ s3_q);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      sync_out <= '0;
    else
      sync_out <= (agree & s3_q) | (~agree & sync_out);
  end

endmodule

`default_nettype wire

/* File: buck_startup_sequencer.sv */
// Purpose: start-up, shutdown, soft-start and retry sequencing
// Assumes: analog comparators deliver the sensed levels as inputs
// Notes:   all outputs registered; long delay is a parameter
//
// Functional notes
// (R1) disable pin low: stop, gates low, re-arm
// (R2) disable release: fresh init and soft-start
// (R3) supply good starts trip-level sampling sequence
// (R4) disable held at power-up postpones init
// (R5) fixed delay after release before sampling
// (R6) delay: low driver off, trip current on
// (R7) sampling lasts zero to maximum time
// (R8) trip level held in counter while powered
// (R9) soft-start starts right after sampling
// (R10) reference ramps zero to final over period
// (R11) ramp in 64 equal fixed steps
// (R12) error amp enabled after short init
// (R13) ramp past final means soft-start done
// (R14) pre-bias below: switches off until ramp passes
// (R15) pre-bias above: switches off until ramp end
// (R16) re-enable after run redoes full init
// (R17) overcurrent retries reuse stored trip level
// (R18) trip: off, two dummy timeouts, restart
// (R19) opposite switch waits for sensed turn-off
// (R20) hiccup repeats while fault persists
// (R21) three narrow low pulses: stretch third
// (R22) no high-side pulses before ramp begins
// (R23) external device releases disable when input valid
`include "buck_seq_map.svh"
`timescale 1ns/100ps
`default_nettype none

module buck_startup_sequencer #(
  parameter int unsigned DELAY_CYC = `SEQ_DELAY_US * `SEQ_CLK_MHZ,
  parameter int unsigned TRIP_BITS = `SEQ_TRIP_BITS
) (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 vcc_above_por,
  input  wire logic                 disable_below_thr,
  input  wire logic                 trip_pin_above_dac,
  input  wire logic                 overcurrent_guard_trip,
  input  wire logic                 pwm_request,
  input  wire logic                 high_side_off_sense,
  input  wire logic                 low_side_off_sense,
  input  wire logic                 ramp_above_output,
  input  wire logic                 osc_phase,
  output var  logic                 osc_enable,
  output var  logic                 high_side_gate,
  output var  logic                 low_side_gate,
  output var  logic                 trip_set_current_en,
  output var  logic [TRIP_BITS-1:0] trip_level_set,
  output var  logic [`SEQ_SS_BITS-1:0] ss_reference,
  output var  logic                 error_amp_enable,
  output var  logic                 soft_start_done,
  output var  logic                 hiccup_active,
  output var  buck_seq_pkg::seq_state_e seq_state
);
  import buck_seq_pkg::*;

  localparam int unsigned SAMPLE_STEP_CYC =
    (`SEQ_SAMPLE_MAX_US * `SEQ_CLK_MHZ) / (1 << TRIP_BITS);
  localparam int unsigned SS_STEP_CYC =
    (`SEQ_SS_TIME_US * `SEQ_CLK_MHZ) / `SEQ_SS_STEPS;
  localparam int unsigned MIN_LOW_CYC =
    (`SEQ_MIN_LOW_NS + `SEQ_CLK_PERIOD_NS - 1) / `SEQ_CLK_PERIOD_NS;
  localparam logic [`SEQ_TIMER_BITS-1:0] DELAY_LAST =
    `SEQ_TIMER_BITS'(DELAY_CYC - 1);
  localparam logic [`SEQ_TIMER_BITS-1:0] SAMPLE_LAST =
    `SEQ_TIMER_BITS'(SAMPLE_STEP_CYC - 1);
  localparam logic [`SEQ_TIMER_BITS-1:0] SS_LAST =
    `SEQ_TIMER_BITS'(SS_STEP_CYC - 1);
  localparam logic [`SEQ_WIDTH_BITS-1:0] MIN_LOW =
    `SEQ_WIDTH_BITS'(MIN_LOW_CYC);
  localparam logic [`SEQ_SS_BITS-1:0] SS_TOP = '1;
  localparam logic [`SEQ_SS_BITS-1:0] EA_INIT =
    `SEQ_SS_BITS'(`SEQ_EA_INIT_STEPS);
  localparam logic [TRIP_BITS-1:0] TRIP_TOP = '1;
  localparam logic [`SEQ_NARROW_BITS-1:0] NARROW_BEFORE =
    `SEQ_NARROW_BITS'(`SEQ_NARROW_BEFORE);

  logic [`SEQ_SYNC_WIDTH-1:0] sync_vec;
  logic vcc_s;
  logic dis_s;
  logic trip_cmp_s;
  logic oc_s;
  logic pwm_s;
  logic hs_off_s;
  logic ls_off_s;
  logic ramp_above_s;
  logic osc_s;

  seq_state_e state_q;
  seq_state_e state_d;
  logic [`SEQ_TIMER_BITS-1:0] tmr_q;
  logic [`SEQ_TIMER_BITS-1:0] tmr_last;
  logic tick;
  logic [`SEQ_SS_BITS-1:0] step_q;
  logic dummy_q;
  logic [TRIP_BITS-1:0] trip_q;
  logic sw_en_q;
  logic hs_q;
  logic ls_q;
  logic osc_prev_q;
  logic osc_edge;
  logic [`SEQ_WIDTH_BITS-1:0] low_w_q;
  logic [`SEQ_NARROW_BITS-1:0] narrow_q;
  logic [`SEQ_WIDTH_BITS-1:0] stretch_q;
  logic stretch;
  logic guard_on;
  logic active;
  logic hs_d;
  logic ls_d;

  pin_sync #(
    .WIDTH(`SEQ_SYNC_WIDTH)
  ) u_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in ({vcc_above_por, disable_below_thr, trip_pin_above_dac,
                overcurrent_guard_trip, pwm_request, high_side_off_sense,
                low_side_off_sense, ramp_above_output, osc_phase}),
    .sync_out (sync_vec)
  );

  assign {vcc_s, dis_s, trip_cmp_s, oc_s, pwm_s, hs_off_s, ls_off_s,
          ramp_above_s, osc_s} = sync_vec;

  // step timer limit per phase
  always_comb
  begin
    unique case (state_q)
      ST_DELAY:  tmr_last = DELAY_LAST;
      ST_SAMPLE: tmr_last = SAMPLE_LAST;
      default:   tmr_last = SS_LAST;
    endcase
  end

  assign tick = (tmr_q == tmr_last);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF:
        // (R3) supply good arms init
        if (vcc_s)
          state_d = ST_WAIT_EN;
      ST_WAIT_EN:
        // (R2) release starts new init
        // (R4) held low keeps waiting
        if (!dis_s)
          state_d = ST_DELAY;
      ST_DELAY:
        // (R5) fixed delay first
        if (tick)
          state_d = ST_SAMPLE;
      ST_SAMPLE:
        // (R7) variable sample length
        // (R9) then soft-start
        if (!trip_cmp_s || (trip_q == TRIP_TOP))
          state_d = ST_RAMP;
      ST_RAMP:
        // (R18) trip aborts the ramp
        if (oc_s)
          state_d = ST_HICCUP;
        // (R13) ramp past final
        else if (tick && (step_q == SS_TOP))
          state_d = ST_RUN;
      ST_RUN:
        if (oc_s)
          state_d = ST_HICCUP;
      ST_HICCUP:
        // (R17) restart skips sampling
        // (R20) cycle repeats on retrip
        if (tick && (step_q == SS_TOP) && dummy_q)
          state_d = ST_RAMP;
      default:
        state_d = ST_OFF;
    endcase
    // (R1) disable re-arms sequence
    // (R16) full init after re-enable
    if (state_q != ST_OFF && dis_s)
      state_d = ST_WAIT_EN;
    // (R8) power loss drops state to ST_OFF
    if (!vcc_s)
      state_d = ST_OFF;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      state_q <= ST_OFF;
    else
      state_q <= state_d;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      tmr_q <= '0;
    else if ((state_d != state_q) || tick)
      tmr_q <= '0;
    else
      tmr_q <= tmr_q + 1'b1;
  end

  // (R10) reference and dummy timeouts share one step counter
  // (R11) 64 equal steps, fixed rate
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      step_q <= '0;
    else if (state_d != state_q)
      step_q <= '0;
    else if (tick && (state_q == ST_RAMP || state_q == ST_HICCUP))
      step_q <= step_q + 1'b1;
  end

  // (R18) two dummy soft-start timeouts
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      dummy_q <= 1'b0;
    else if (state_q != ST_HICCUP)
      dummy_q <= 1'b0;
    else if (tick && (step_q == SS_TOP))
      dummy_q <= 1'(`SEQ_DUMMY_LAST);
  end

  // (R8) counter holds trip level
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      trip_q <= '0;
    else if (state_q == ST_OFF || state_q == ST_DELAY)
      trip_q <= '0;
    else if (state_q == ST_SAMPLE && tick && trip_cmp_s &&
             (trip_q != TRIP_TOP))
      trip_q <= trip_q + 1'b1;
  end

  // (R14) switching waits for ramp over output
  // (R15) or for the end of the ramp
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      sw_en_q <= 1'b0;
    else if (state_q != ST_RAMP && state_q != ST_RUN)
      sw_en_q <= 1'b0;
    else if (ramp_above_s || state_q == ST_RUN)
      sw_en_q <= 1'b1;
  end

  // low pulse width per oscillator cycle
  assign osc_edge = osc_s & ~osc_prev_q;
  assign stretch  = (stretch_q != '0);
  assign guard_on = (trip_q != TRIP_TOP);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      osc_prev_q <= 1'b0;
    else
      osc_prev_q <= osc_s;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      low_w_q <= '0;
    else if (osc_edge)
      low_w_q <= '0;
    else if (ls_q && low_w_q != MIN_LOW)
      low_w_q <= low_w_q + 1'b1;
  end

  // (R21) third narrow pulse stretched
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      narrow_q  <= '0;
      stretch_q <= '0;
    end
    else if (!active || !guard_on)
    begin
      narrow_q  <= '0;
      stretch_q <= '0;
    end
    else if (osc_edge)
    begin
      if (low_w_q < MIN_LOW && narrow_q == NARROW_BEFORE)
      begin
        narrow_q  <= '0;
        stretch_q <= MIN_LOW;
      end
      else if (low_w_q < MIN_LOW)
        narrow_q <= narrow_q + 1'b1;
      else
        narrow_q <= '0;
    end
    else if (stretch && ls_q)
      stretch_q <= stretch_q - 1'b1;
  end

  // (R22) no switching before ramp
  assign active = (state_q == ST_RAMP || state_q == ST_RUN) && sw_en_q;

  // (R19) each side waits for the other to be off
  always_comb
  begin
    hs_d = active & pwm_s & ls_off_s & ~ls_q & ~stretch;
    ls_d = active & hs_off_s & ~hs_q & (~pwm_s | stretch);
  end

  // (R1) gates low while disabled
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      hs_q <= 1'b0;
      ls_q <= 1'b0;
    end
    else
    begin
      hs_q <= hs_d;
      ls_q <= ls_d;
    end
  end

  assign high_side_gate = hs_q;
  assign low_side_gate  = ls_q;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      osc_enable          <= 1'b0;
      trip_set_current_en <= 1'b0;
      trip_level_set      <= '0;
      ss_reference        <= '0;
      error_amp_enable    <= 1'b0;
      soft_start_done     <= 1'b0;
      hiccup_active       <= 1'b0;
      seq_state           <= ST_OFF;
    end
    else
    begin
      // (R1) oscillator stopped
      osc_enable <= (state_q != ST_OFF && state_q != ST_WAIT_EN);
      // (R6) trip current during delay
      trip_set_current_en <= (state_q == ST_DELAY ||
                              state_q == ST_SAMPLE);
      trip_level_set <= trip_q;
      // (R10) ramping reference
      ss_reference <= (state_q == ST_RUN) ? SS_TOP :
                      (state_q == ST_RAMP) ? step_q : '0;
      // (R12) error amp after init
      error_amp_enable <= (state_q == ST_RUN) ||
                          (state_q == ST_RAMP && step_q >= EA_INIT);
      soft_start_done <= (state_q == ST_RUN);
      hiccup_active   <= (state_q == ST_HICCUP);
      seq_state       <= state_q;
    end
  end

endmodule

`default_nettype wire

/* File: buck_seq_asserts.sv */
// Purpose: port assertions of the start-up sequencer
// Assumes: 10 MHz mclk, inputs synchronised inside the block
// Notes:   bound to every sequencer instance at the foot
`include "buck_seq_map.svh"
`timescale 1ns/100ps
`default_nettype none

module buck_seq_asserts #(
  parameter int unsigned DELAY_CYC = 68000,
  parameter int unsigned TRIP_BITS = 6
) (
  input wire logic                       mclk,
  input wire logic                       rst,
  input wire logic                       disable_below_thr,
  input wire logic                       overcurrent_guard_trip,
  input wire logic                       ramp_above_output,
  input wire logic                       high_side_off_sense,
  input wire logic                       low_side_off_sense,
  input wire logic                       osc_enable,
  input wire logic                       high_side_gate,
  input wire logic                       low_side_gate,
  input wire logic                       trip_set_current_en,
  input wire logic [TRIP_BITS-1:0]       trip_level_set,
  input wire logic [`SEQ_SS_BITS-1:0]    ss_reference,
  input wire logic                       hiccup_active,
  input wire buck_seq_pkg::seq_state_e   seq_state
);
  import buck_seq_pkg::*;
  localparam int SMP_MAX = 64 * 531 + 2;
  localparam int RAMP_LO = 64 * 1062 - 2;
  localparam int RAMP_HI = 64 * 1062 + 2;
  seq_state_e  st_q;
  logic [17:0] cnt_q;

  // run length of the previous state
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_q  <= ST_OFF;
      cnt_q <= 18'h0;
    end
    else
    begin
      st_q  <= seq_state;
      cnt_q <= (seq_state == st_q) ? cnt_q + 18'h1 : 18'h1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  chk_dis_gates_off: assert property (
    disable_below_thr [*8] |-> !osc_enable && !high_side_gate
    && !low_side_gate && seq_state inside {ST_OFF, ST_WAIT_EN})
    else $error("switching while disabled");
  chk_delay_setup: assert property (
    seq_state == ST_DELAY && st_q == ST_DELAY |-> trip_set_current_en
    && !low_side_gate && !high_side_gate)
    else $error("delay phase drive wrong");
  chk_delay_len: assert property (
    seq_state == ST_SAMPLE && st_q == ST_DELAY |->
    cnt_q >= DELAY_CYC - 1 && cnt_q <= DELAY_CYC + 1)
    else $error("delay length wrong");
  chk_sample_max: assert property (
    st_q == ST_SAMPLE |-> cnt_q <= SMP_MAX)
    else $error("sampling too long");
  chk_hold_trip: assert property (
    st_q inside {ST_RAMP, ST_RUN, ST_HICCUP}
    && seq_state inside {ST_RAMP, ST_RUN, ST_HICCUP}
    |-> $stable(trip_level_set))
    else $error("trip level changed");
  chk_step_size: assert property (
    seq_state == ST_RAMP && st_q == ST_RAMP && !$stable(ss_reference)
    |-> ss_reference == $past(ss_reference) + 6'h01)
    else $error("ramp step not one");
  chk_ramp_len: assert property (
    seq_state == ST_RUN && st_q == ST_RAMP |->
    cnt_q >= RAMP_LO && cnt_q <= RAMP_HI)
    else $error("ramp length wrong");
  chk_prebias_off: assert property (
    (seq_state == ST_RAMP && !ramp_above_output) [*6]
    |-> !high_side_gate && !low_side_gate)
    else $error("switching under pre-bias");
  chk_oc_enter: assert property (
    (seq_state == ST_RUN && overcurrent_guard_trip && !disable_below_thr
    && !(&trip_level_set)) [*4] |-> ##[1:8] seq_state == ST_HICCUP)
    else $error("no retry on overcurrent");
  chk_hiccup_quiet: assert property (
    seq_state == ST_HICCUP && st_q == ST_HICCUP |-> hiccup_active
    && !high_side_gate && !low_side_gate)
    else $error("switching in retry");
  chk_hs_wait: assert property (
    $rose(high_side_gate) |-> !low_side_gate
    && $past(low_side_off_sense, 3))
    else $error("high side before low off");
  chk_ls_wait: assert property (
    $rose(low_side_gate) |-> !high_side_gate
    && $past(high_side_off_sense, 3))
    else $error("low side before high off");
endmodule

bind buck_startup_sequencer buck_seq_asserts #(
  .DELAY_CYC(DELAY_CYC),
  .TRIP_BITS(TRIP_BITS)
) u_asserts (
  .mclk, .rst, .disable_below_thr, .overcurrent_guard_trip,
  .ramp_above_output, .high_side_off_sense, .low_side_off_sense,
  .osc_enable, .high_side_gate, .low_side_gate, .trip_set_current_en,
  .trip_level_set, .ss_reference, .hiccup_active, .seq_state
);
`default_nettype wire

/* File: gate_partner.sv */
// Purpose: disable pull-down and power switch model
// Assumes: switch off-sense lags gate fall by OFF_DLY clocks
// Notes:   released pin needs RISE_CYC clocks to cross threshold
`timescale 1ns/100ps
`default_nettype none

module gate_partner #(
  parameter int unsigned OFF_DLY  = 3,
  parameter int unsigned RISE_CYC = 6
) (
  input  wire logic mclk,
  input  wire logic pull_low,
  input  wire logic vin_ok,
  input  wire logic high_side_gate,
  input  wire logic low_side_gate,
  output var  logic disable_below_thr,
  output var  logic high_side_off_sense,
  output var  logic low_side_off_sense
);
  logic [3:0] hs_q = 4'h0;
  logic [3:0] ls_q = 4'h0;
  logic [3:0] rise_q = 4'h0;

  // gate charge drains slowly
  always_ff @(posedge mclk)
  begin
    hs_q <= high_side_gate ? 4'h0 : hs_q + 4'(hs_q < OFF_DLY);
    ls_q <= low_side_gate ? 4'h0 : ls_q + 4'(ls_q < OFF_DLY);
  end

  always_ff @(posedge mclk)
  begin
    rise_q <= (pull_low || !vin_ok) ? 4'h0
              : rise_q + 4'(rise_q < RISE_CYC);
  end

  assign disable_below_thr   = rise_q < RISE_CYC;
  assign high_side_off_sense = hs_q >= OFF_DLY;
  assign low_side_off_sense  = ls_q >= OFF_DLY;
endmodule
`default_nettype wire

/* File: tb_buck_startup_sequencer.sv */
// Purpose: self-checking bench of the start-up sequencer
// Assumes: short init delay, 32-clock oscillator stand-in
// Notes:   one full ramp; end of retry wait is not reached
`timescale 1ns/100ps
`default_nettype none

module tb_buck_startup_sequencer;
  import buck_seq_pkg::*;
  localparam int DLY = 40;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic       vcc_above_por = 1'b0;
  logic       pull_low = 1'b1;
  logic       vin_ok = 1'b0;
  logic       trip_pin_above_dac = 1'b0;
  logic       overcurrent_guard_trip = 1'b0;
  logic       pwm_request = 1'b0;
  logic       ramp_above_output = 1'b0;
  logic       osc_phase = 1'b0;
  logic       pwm_full = 1'b0;
  logic [5:0] trip_target = 6'h05;
  logic [4:0] osc_q = 5'h0;
  logic       disable_below_thr, high_side_off_sense, low_side_off_sense;
  logic       osc_enable, high_side_gate, low_side_gate;
  logic       trip_set_current_en, error_amp_enable;
  logic       soft_start_done, hiccup_active;
  logic [5:0] trip_level_set, ss_reference;
  seq_state_e seq_state;
  int         mismatches = 0;
  int         num_checks = 0;

  buck_startup_sequencer #(
    .DELAY_CYC(DLY)
  ) DUT (
    .mclk, .rst, .vcc_above_por, .disable_below_thr, .trip_pin_above_dac,
    .overcurrent_guard_trip, .pwm_request, .high_side_off_sense,
    .low_side_off_sense, .ramp_above_output, .osc_phase, .osc_enable,
    .high_side_gate, .low_side_gate, .trip_set_current_en,
    .trip_level_set, .ss_reference, .error_amp_enable, .soft_start_done,
    .hiccup_active, .seq_state
  );

  gate_partner u_partner (
    .mclk, .pull_low, .vin_ok, .high_side_gate, .low_side_gate,
    .disable_below_thr, .high_side_off_sense, .low_side_off_sense
  );

  initial
  begin
    forever #50 mclk = ~mclk;
  end

  // oscillator, pwm and trip comparator stand-ins
  always @(posedge mclk)
  begin
    osc_q <= osc_q + 5'h1;
    osc_phase <= osc_q[4];
    pwm_request <= pwm_full || (osc_q < 5'h10);
    trip_pin_above_dac <= trip_level_set < trip_target;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_st(input seq_state_e s, input int lim, output int n);
    n = 0;
    while (seq_state !== s && n < lim)
    begin
      @(negedge mclk);
      n++;
    end
    check("state", s, seq_state);
    if (seq_state !== s)
      finish_test();
  endtask

  task automatic watch(input int c, output int hs, output int ls);
    hs = 0;
    ls = 0;
    repeat (c)
    begin
      @(negedge mclk);
      hs += high_side_gate;
      ls += low_side_gate;
    end
  endtask

  task automatic t_power_up();
    int n;
    repeat (20) @(negedge mclk);
    check("state", ST_OFF, seq_state);
    @(posedge mclk) vcc_above_por <= 1'b1;
    repeat (20) @(negedge mclk);
    check("state", ST_WAIT_EN, seq_state);
    @(posedge mclk) pull_low <= 1'b0;
    repeat (20) @(negedge mclk);
    check("osc", 0, osc_enable);
    @(posedge mclk) vin_ok <= 1'b1;
    wait_st(ST_DELAY, 30, n);
    repeat (3) @(negedge mclk);
    check("trip_cur", 1, trip_set_current_en);
    check("low_gate", 0, low_side_gate);
    wait_st(ST_SAMPLE, DLY + 10, n);
    check("delay", 1, n > DLY - 8);
    wait_st(ST_RAMP, 64 * 531, n);
    check("smp_time", 1, n > 4 * 531 && n < 6 * 531);
    check("trip", 5, trip_level_set);
    $display("test power_up done");
  endtask

  task automatic t_ramp();
    int hs;
    int ls;
    logic [5:0] r;
    watch(3000, hs, ls);
    check("prebias", 0, hs + ls != 0);
    check("ea", 1, error_amp_enable);
    @(posedge mclk) ramp_above_output <= 1'b1;
    watch(200, hs, ls);
    check("switching", 1, hs != 0);
    r = ss_reference;
    repeat (1062) @(negedge mclk);
    check("ref_step", r + 6'h01, ss_reference);
    wait_st(ST_RUN, 64 * 1062, hs);
    check("ref_end", 6'h3f, ss_reference);
    check("done", 1, soft_start_done);
    @(posedge mclk) pwm_full <= 1'b1;
    watch(200, hs, ls);
    check("stretch", 1, ls >= 5);
    @(posedge mclk) pwm_full <= 1'b0;
    $display("test ramp done");
  endtask

  task automatic t_overcurrent();
    int hs;
    int ls;
    @(posedge mclk) overcurrent_guard_trip <= 1'b1;
    wait_st(ST_HICCUP, 20, hs);
    @(posedge mclk) overcurrent_guard_trip <= 1'b0;
    watch(100, hs, ls);
    check("hiccup", 1, hiccup_active);
    check("gates", 0, hs + ls != 0);
    check("trip_keep", 5, trip_level_set);
    $display("test overcurrent done");
  endtask

  task automatic t_reenable();
    int n;
    @(posedge mclk) pull_low <= 1'b1;
    @(posedge mclk) trip_target <= 6'h09;
    wait_st(ST_WAIT_EN, 20, n);
    repeat (3) @(negedge mclk);
    check("osc", 0, osc_enable);
    check("hs_gate", 0, high_side_gate);
    @(posedge mclk) pull_low <= 1'b0;
    wait_st(ST_DELAY, 30, n);
    wait_st(ST_SAMPLE, DLY + 10, n);
    wait_st(ST_RAMP, 64 * 531, n);
    check("trip_new", 9, trip_level_set);
    $display("test reenable done");
  endtask

  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_power_up();
    t_ramp();
    t_overcurrent();
    t_reenable();
    finish_test();
  end
endmodule
`default_nettype wire
